// *** src/timer_pkg.sv ***
// constants, layouts and carrier types of the auto-reload pwm timer
package timer_pkg;

   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   localparam int ADDR_W = 9;
   localparam int DATA_W = 32;
   localparam int IDX_W = 7;

   // register index; the byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_DUTY3 = 7'h73;
   localparam logic [IDX_W-1:0] IDX_DUTY2 = 7'h74;
   localparam logic [IDX_W-1:0] IDX_DUTY1 = 7'h75;
   localparam logic [IDX_W-1:0] IDX_DUTY0 = 7'h76;
   localparam logic [IDX_W-1:0] IDX_PWM_CTRL = 7'h77;
   localparam logic [IDX_W-1:0] IDX_TIMER_CSR = 7'h78;
   localparam logic [IDX_W-1:0] IDX_COUNTER = 7'h79;
   localparam logic [IDX_W-1:0] IDX_RELOAD = 7'h7A;
   localparam logic [IDX_W-1:0] IDX_CAP_CSR = 7'h7B;
   localparam logic [IDX_W-1:0] IDX_CAP1 = 7'h7C;
   localparam logic [IDX_W-1:0] IDX_CAP2 = 7'h7D;

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] COUNT_TOP = 8'hFF;
   localparam int PRESC_W = 7;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CSR_EXT = 7;
   localparam int CSR_PSEL_HI = 6;
   localparam int CSR_PSEL_LO = 4;
   localparam int CSR_RUN = 3;
   localparam int CSR_FORCE = 2;
   localparam int CSR_OIE = 1;
   localparam int CSR_OVF = 0;
   localparam int PWM_OE_LO = 4;
   localparam int PWM_POL_LO = 0;
   localparam int ICC_SENS_LO = 4;
   localparam int ICC_IE_LO = 2;
   localparam int ICC_CF_LO = 0;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] address;
      logic read;
      logic write;
      logic [DATA_W-1:0] writedata;
      logic [3:0] byteenable;
   } avmm_req_t;

   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ANSWER = 2'b10
   } bus_state_t;

endpackage

// *** src/pin_edge_detect.sv ***
// two-flop synchroniser with rising and falling edge pulses
`timescale 1ns/1ps
module pin_edge_detect (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // asynchronous pin
   input wire logic pin,
   // edge pulses
   output logic rise,
   output logic fall
);
   logic meta;
   logic sync;
   logic prev;
   logic [2:0] armed;

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= pin;
         sync <= meta;
         prev <= sync;
      end
   end

   // edges held off until prev holds a real pin sample, so a pin that
   // idles high gives no false edge after reset
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         armed <= 3'h0;
         rise <= 1'b0;
         fall <= 1'b0;
      end else begin
         armed <= {armed[1:0], 1'b1};
         rise <= armed[2] & sync & ~prev;
         fall <= armed[2] & ~sync & prev;
      end
   end
endmodule // pin_edge_detect

// *** src/pwm_channel.sv ***
// one pwm channel: compare shadow, level and pin drive
`timescale 1ns/1ps
module pwm_channel (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // timer state
   input wire logic ovf_evt,
   input wire logic [7:0] count,
   input wire logic [7:0] duty_cycle_reg,
   // channel control
   input wire logic polarity,
   input wire logic enable,
   // pin
   output logic pin,
   output logic pin_oe
);
   import timer_pkg::*;
   logic [7:0] compare_shadow;

   // shadow loaded only at overflow, so duty changes never glitch
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         compare_shadow <= REG_RESET;
      end else if (ovf_evt) begin
         compare_shadow <= duty_cycle_reg;
      end
   end

   // level high up to compare, low above; polarity flips at once
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pin <= 1'b0;
         pin_oe <= 1'b0;
      end else begin
         pin <= enable & ((count <= compare_shadow) ^ polarity);
         pin_oe <= enable;
      end
   end
endmodule // pwm_channel

// *** src/autoreload_pwm_timer_regs.sv ***
// 8-bit auto-reload pwm timer with input capture, avalon-mm slave
//
// Design decision made here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module autoreload_pwm_timer_regs (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // avalon-mm slave
   input wire timer_pkg::avmm_req_t avs_req,
   output logic [timer_pkg::DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   // external pins
   input wire logic ext_clk_pin,
   input wire logic [1:0] capture_pin,
   // pwm pins
   output logic [3:0] pwm_out_channel,
   output logic [3:0] pwm_pin_oe,
   // interrupt requests
   output logic overflow_irq,
   output logic [1:0] capture_irq
);
   import timer_pkg::*;

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   logic [7:0] duty [4];
   logic [3:0] polarity_bits;
   logic [3:0] out_enable;
   logic ext_clock_select;
   logic [2:0] prescale_select;
   logic counter_run_enable;
   logic overflow_irq_enable;
   logic overflow_flag;
   logic [7:0] counter;
   logic [7:0] reload_value;
   logic [1:0] capture_sens;
   logic [1:0] capture_irq_enable;
   logic [1:0] capture_flag;
   logic [7:0] capture_value [2];
   logic [PRESC_W-1:0] prescaler;

   bus_state_t bus_state;
   logic rd_ovf_seen;
   logic [1:0] rd_cf_seen;

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic req;
   logic accept;
   logic wr_en;
   logic [IDX_W-1:0] idx;
   logic aligned;
   logic [7:0] wdata;

   assign req = avs_req.read | avs_req.write;
   assign accept = req & ~avs_waitrequest;
   assign idx = avs_req.address[ADDR_W-1:2];
   assign aligned = (avs_req.address[1:0] == 2'h0);
   assign wdata = avs_req.writedata[7:0];
   assign wr_en = accept & avs_req.write & avs_req.byteenable[0] & aligned;

   logic wr_duty3, wr_duty2, wr_duty1, wr_duty0;
   logic wr_pwm, wr_csr, wr_cnt, wr_rel, wr_icc;
   logic rd_csr, rd_cap1, rd_cap2;

   assign wr_duty3 = wr_en & (idx == IDX_DUTY3);
   assign wr_duty2 = wr_en & (idx == IDX_DUTY2);
   assign wr_duty1 = wr_en & (idx == IDX_DUTY1);
   assign wr_duty0 = wr_en & (idx == IDX_DUTY0);
   assign wr_pwm = wr_en & (idx == IDX_PWM_CTRL);
   assign wr_csr = wr_en & (idx == IDX_TIMER_CSR);
   assign wr_cnt = wr_en & (idx == IDX_COUNTER);
   assign wr_rel = wr_en & (idx == IDX_RELOAD);
   assign wr_icc = wr_en & (idx == IDX_CAP_CSR);
   assign rd_csr = accept & avs_req.read & aligned & (idx == IDX_TIMER_CSR);
   assign rd_cap1 = accept & avs_req.read & aligned & (idx == IDX_CAP1);
   assign rd_cap2 = accept & avs_req.read & aligned & (idx == IDX_CAP2);

   // ----------------------------------------------------------------
   // bus handshake: one wait cycle, data latched with the answer
   // ----------------------------------------------------------------
   logic [7:0] next_readdata;

   always_comb begin
      next_readdata = 8'h00;
      if (!aligned) begin
         next_readdata = 8'h00;
      end else if (idx == IDX_DUTY3) begin
         next_readdata = duty[3];
      end else if (idx == IDX_DUTY2) begin
         next_readdata = duty[2];
      end else if (idx == IDX_DUTY1) begin
         next_readdata = duty[1];
      end else if (idx == IDX_DUTY0) begin
         next_readdata = duty[0];
      end else if (idx == IDX_PWM_CTRL) begin
         next_readdata = {out_enable, polarity_bits};
      end else if (idx == IDX_TIMER_CSR) begin
         next_readdata = {ext_clock_select, prescale_select,
            counter_run_enable, 1'b0, overflow_irq_enable,
            overflow_flag};
      end else if (idx == IDX_COUNTER) begin
         next_readdata = counter;
      end else if (idx == IDX_RELOAD) begin
         next_readdata = reload_value;
      end else if (idx == IDX_CAP_CSR) begin
         next_readdata = {2'b00, capture_sens, capture_irq_enable,
            capture_flag};
      end else if (idx == IDX_CAP1) begin
         next_readdata = capture_value[0];
      end else if (idx == IDX_CAP2) begin
         next_readdata = capture_value[1];
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         bus_state <= BUS_IDLE;
         avs_waitrequest <= 1'b1;
         avs_readdata <= '0;
         rd_ovf_seen <= 1'b0;
         rd_cf_seen <= 2'b00;
      end else begin
         case (bus_state)
            BUS_IDLE: begin
               if (req) begin
                  bus_state <= BUS_ANSWER;
                  avs_waitrequest <= 1'b0;
                  avs_readdata <= {24'h000000, next_readdata};
                  rd_ovf_seen <= overflow_flag;
                  rd_cf_seen <= capture_flag;
               end
            end
            BUS_ANSWER: begin
               bus_state <= BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
            default: begin
               bus_state <= BUS_IDLE;
               avs_waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         for (int i = 0; i < 4; i++) begin
            duty[i] <= REG_RESET;
         end
         polarity_bits <= 4'h0;
         out_enable <= 4'h0;
         ext_clock_select <= 1'b0;
         prescale_select <= 3'h0;
         counter_run_enable <= 1'b0;
         overflow_irq_enable <= 1'b0;
         reload_value <= REG_RESET;
         capture_sens <= 2'h0;
         capture_irq_enable <= 2'h0;
      end else begin
         if (wr_duty3) duty[3] <= wdata;
         if (wr_duty2) duty[2] <= wdata;
         if (wr_duty1) duty[1] <= wdata;
         if (wr_duty0) duty[0] <= wdata;
         if (wr_pwm) begin
            out_enable <= wdata[PWM_OE_LO +: 4];
            polarity_bits <= wdata[PWM_POL_LO +: 4];
         end
         if (wr_csr) begin
            ext_clock_select <= wdata[CSR_EXT];
            prescale_select <= wdata[CSR_PSEL_HI:CSR_PSEL_LO];
            counter_run_enable <= wdata[CSR_RUN];
            overflow_irq_enable <= wdata[CSR_OIE];
         end
         if (wr_rel) reload_value <= wdata;
         if (wr_icc) begin
            capture_sens <= wdata[ICC_SENS_LO +: 2];
            capture_irq_enable <= wdata[ICC_IE_LO +: 2];
         end
      end
   end

   // ----------------------------------------------------------------
   // input clock, prescaler and counter
   // ----------------------------------------------------------------
   logic ext_rise;
   logic [1:0] cap_rise;
   logic [1:0] cap_fall;

   pin_edge_detect ext_edge (
      .mclk(mclk),
      .rst_b(rst_b),
      .pin(ext_clk_pin),
      .rise(ext_rise),
      .fall()
   );

   logic in_tick;
   logic cnt_tick;
   logic ovf_evt;
   logic force_load;
   logic [PRESC_W-1:0] tap_mask;

   assign in_tick = counter_run_enable & (ext_clock_select ? ext_rise : 1'b1);
   assign tap_mask = PRESC_W'((8'h01 << prescale_select) - 8'h01);
   assign cnt_tick = in_tick & ((prescaler & tap_mask) == tap_mask);
   assign ovf_evt = cnt_tick & (counter == COUNT_TOP) & ~wr_cnt & ~force_load;
   assign force_load = wr_csr & wdata[CSR_FORCE];

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         prescaler <= '0;
      end else if (force_load || wr_cnt) begin
         prescaler <= '0;
      end else if (in_tick) begin
         prescaler <= prescaler + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         counter <= REG_RESET;
      end else if (wr_cnt) begin
         counter <= wdata;
      end else if (force_load) begin
         counter <= reload_value;
      end else if (ovf_evt) begin
         counter <= reload_value;
      end else if (cnt_tick) begin
         counter <= counter + 8'h01;
      end
   end

   // set wins over a clear; only a flag that was read is cleared
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         overflow_flag <= 1'b0;
      end else if (ovf_evt) begin
         overflow_flag <= 1'b1;
      end else if (rd_csr && rd_ovf_seen) begin
         overflow_flag <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // input capture
   // ----------------------------------------------------------------
   logic [1:0] cap_evt;
   logic [1:0] rd_cap;

   assign rd_cap = {rd_cap2, rd_cap1};

   for (genvar c = 0; c < 2; c++) begin : g_cap
      pin_edge_detect cap_edge (
         .mclk(mclk),
         .rst_b(rst_b),
         .pin(capture_pin[c]),
         .rise(cap_rise[c]),
         .fall(cap_fall[c])
      );

      assign cap_evt[c] = capture_sens[c] ? cap_rise[c] : cap_fall[c];

      always_ff @(posedge mclk) begin
         if (!rst_b) begin
            capture_value[c] <= REG_RESET;
         end else if (cap_evt[c] && !capture_flag[c]) begin
            capture_value[c] <= counter;
         end
      end

      always_ff @(posedge mclk) begin
         if (!rst_b) begin
            capture_flag[c] <= 1'b0;
         end else if (cap_evt[c] && !capture_flag[c]) begin
            capture_flag[c] <= 1'b1;
         end else if (rd_cap[c] && rd_cf_seen[c]) begin
            capture_flag[c] <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // interrupt requests
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         overflow_irq <= 1'b0;
         capture_irq <= 2'b00;
      end else begin
         overflow_irq <= overflow_flag & overflow_irq_enable;
         capture_irq <= capture_flag & capture_irq_enable;
      end
   end

   // ----------------------------------------------------------------
   // pwm channels
   // ----------------------------------------------------------------
   for (genvar p = 0; p < 4; p++) begin : g_pwm
      pwm_channel chan (
         .mclk(mclk),
         .rst_b(rst_b),
         .ovf_evt(ovf_evt),
         .count(counter),
         .duty_cycle_reg(duty[p]),
         .polarity(polarity_bits[p]),
         .enable(out_enable[p]),
         .pin(pwm_out_channel[p]),
         .pin_oe(pwm_pin_oe[p])
      );
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   sequence bus_csr_read_s;
      rd_csr && rd_ovf_seen && !ovf_evt;
   endsequence

   sequence overflow_s;
      ovf_evt && overflow_irq_enable && !wr_csr;
   endsequence

   force_reload_a: assert property (@(posedge mclk) disable iff (!rst_b)
      force_load && !wr_cnt |=> counter == $past(reload_value) && prescaler == '0)
      else $error("force reload did not load counter");

   force_reads_zero_a: assert property (@(posedge mclk) disable iff (!rst_b)
      rd_csr |-> !avs_readdata[CSR_FORCE])
      else $error("force reload bit read as one");

   ovf_irq_a: assert property (@(posedge mclk) disable iff (!rst_b)
      overflow_s |=> overflow_flag ##1 overflow_irq)
      else $error("overflow interrupt not raised");

   ovf_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
      ovf_evt |=> overflow_flag && counter == $past(reload_value))
      else $error("overflow did not reload or flag");

   ovf_clear_a: assert property (@(posedge mclk) disable iff (!rst_b)
      bus_csr_read_s |=> !overflow_flag)
      else $error("overflow flag not cleared by read");

   cnt_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_cnt |=> counter == $past(wdata) && prescaler == '0)
      else $error("counter write lost");

   run_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
      !counter_run_enable && !wr_en |=> $stable(counter) && $stable(prescaler))
      else $error("counter moved while stopped");

   cap_block_a: assert property (@(posedge mclk) disable iff (!rst_b)
      capture_flag[0] && !rd_cap1 |=> $stable(capture_value[0]) && capture_flag[0])
      else $error("capture overwritten while flagged");

   cap_reserved_a: assert property (@(posedge mclk) disable iff (!rst_b)
      accept && avs_req.read && aligned && idx == IDX_CAP_CSR
         |-> avs_readdata[7:6] == 2'b00)
      else $error("reserved capture bits read as one");

endmodule // autoreload_pwm_timer_regs

// *** verification/pin_partner.sv ***
// pin-side partner: capture sources and external count clock
`timescale 1ns/1ps
module pin_partner (
   // clock
   input wire logic mclk,
   // pins from the timer
   input wire logic [3:0] pwm_out_channel,
   input wire logic [3:0] pwm_pin_oe,
   // pins to the timer
   output logic [1:0] capture_pin,
   output logic ext_clk_pin
);
   // ----------------------------------------------------------------
   // pin levels
   // ----------------------------------------------------------------
   logic [3:0] pwm_wire;
   // an undriven pwm pin floats, shown as a level that keeps changing
   always @(posedge mclk) begin
      pwm_wire <= (pwm_pin_oe & pwm_out_channel) | (~pwm_pin_oe & ~pwm_wire);
   end
   initial begin
      pwm_wire = 4'h0;
      capture_pin = 2'b10;
      ext_clk_pin = 1'b0;
   end
   // each level stands well beyond the two-cycle minimum
   task automatic drive_cap(input logic [1:0] lvl);
      @(posedge mclk);
      capture_pin <= lvl;
      repeat (8) @(posedge mclk);
   endtask
   task automatic ext_pulses(input int n);
      repeat (n) begin
         @(posedge mclk);
         ext_clk_pin <= 1'b1;
         repeat (4) @(posedge mclk);
         ext_clk_pin <= 1'b0;
         repeat (4) @(posedge mclk);
      end
   endtask
endmodule // pin_partner

// *** verification/tb_top.sv ***
// self-checking bench for the auto-reload pwm timer
`timescale 1ns/1ps
module tb_top;
   import timer_pkg::*;
   // ----------------------------------------------------------------
   // signals and model state
   // ----------------------------------------------------------------
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   avmm_req_t req = '0;
   logic [DATA_W-1:0] rdata;
   logic wait_r;
   logic ovf_irq;
   logic [3:0] pwm;
   logic [3:0] oe;
   logic [1:0] cap_pin;
   logic [1:0] cap_irq;
   logic ext_pin;
   int failures = 0;
   int checked = 0;
   int cyc = 0;
   int t0;
   int c;
   logic [7:0] v;
   logic [7:0] pc;
   logic [7:0] duty [4];
   logic [7:0] shad [4];

   always #20 mclk = ~mclk;

   autoreload_pwm_timer_regs i_dut (
      .mclk(mclk),
      .rst_b(rst_b),
      .avs_req(req),
      .avs_readdata(rdata),
      .avs_waitrequest(wait_r),
      .ext_clk_pin(ext_pin),
      .capture_pin(cap_pin),
      .pwm_out_channel(pwm),
      .pwm_pin_oe(oe),
      .overflow_irq(ovf_irq),
      .capture_irq(cap_irq)
   );

   pin_partner i_pins (
      .mclk(mclk),
      .pwm_out_channel(pwm),
      .pwm_pin_oe(oe),
      .capture_pin(cap_pin),
      .ext_clk_pin(ext_pin)
   );

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic give_verdict();
      if (failures == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         give_verdict();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one avalon transfer; completes at the edge that sees waitrequest low
   task automatic bus(input logic [IDX_W-1:0] idx, input logic wr_en,
                      input logic [7:0] wd, input logic [1:0] lo,
                      input logic be0, output logic [7:0] rd);
      @(posedge mclk);
      req.address <= {idx, lo};
      req.read <= ~wr_en;
      req.write <= wr_en;
      req.writedata <= {24'($urandom()), wd};
      req.byteenable <= {3'($urandom()), be0};
      do begin
         @(posedge mclk);
      end while (wait_r !== 1'b0);
      rd = rdata[7:0];
      req.read <= 1'b0;
      req.write <= 1'b0;
   endtask

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d);
      logic [7:0] x;
      bus(idx, 1'b1, d, 2'b00, 1'b1, x);
   endtask

   task automatic rdc(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
      logic [7:0] x;
      bus(idx, 1'b0, 8'h00, 2'b00, 1'b1, x);
      chk(x, exp);
   endtask

   // one overflow from a single external edge; shadows take the duties
   task automatic ext_ovf(input logic [7:0] csr);
      wr(IDX_COUNTER, 8'hFF);
      wr(IDX_TIMER_CSR, csr);
      i_pins.ext_pulses(1);
      repeat (6) @(posedge mclk);
      shad = duty;
   endtask

   task automatic pwm_chk(input logic [7:0] ctl, input logic [7:0] cnt);
      logic [3:0] e;
      for (int i = 0; i < 4; i++)
         e[i] = ctl[i+4] & ((cnt <= shad[i]) ^ ctl[i]);
      wr(IDX_PWM_CTRL, ctl);
      wr(IDX_COUNTER, cnt);
      repeat (3) @(posedge mclk);
      chk(8'(pwm), 8'(e));
      chk(8'(oe), 8'(ctl[7:4]));
      chk(8'(i_pins.pwm_wire & ctl[7:4]), 8'(e));
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      v = 8'($urandom(32'h3825));
      repeat (6) @(posedge mclk);
      rst_b <= 1'b1;
      for (int i = 'h73; i <= 'h7D; i++) begin
         rdc(7'(i), 8'h00);
      end
      rdc(7'h10, 8'h00);
      for (int i = 0; i < 4; i++) begin
         duty[i] = 8'($urandom());
         wr(7'(IDX_DUTY0 - i), duty[i]);
         rdc(7'(IDX_DUTY0 - i), duty[i]);
      end
      wr(IDX_CAP1, 8'h5A);
      rdc(IDX_CAP1, 8'h00);
      // prescaler taps, counted from a forced reload
      wr(IDX_RELOAD, 8'h10);
      for (int p = 3; p < 8; p++) begin
         wr(IDX_TIMER_CSR, 8'(8'h0C | (p << 4)));
         t0 = cyc;
         rdc(IDX_TIMER_CSR, 8'(8'h08 | (p << 4)));
         repeat ((3 << p) + (1 << (p - 1)) - 6) @(posedge mclk);
         wr(IDX_TIMER_CSR, 8'h00);
         c = cyc - t0;
         rdc(IDX_COUNTER, 8'(16 + (c >> p)));
      end
      repeat (200) @(posedge mclk);
      rdc(IDX_COUNTER, 8'(16 + (c >> 7)));
      wr(IDX_TIMER_CSR, 8'h8C);
      i_pins.ext_pulses(5);
      repeat (6) @(posedge mclk);
      rdc(IDX_COUNTER, 8'h15);
      // overflow with the interrupt enabled, then masked
      wr(IDX_RELOAD, 8'hF0);
      rdc(IDX_RELOAD, 8'hF0);
      // writes without byte 0 or off the word boundary leave it alone
      bus(IDX_RELOAD, 1'b1, 8'h55, 2'b00, 1'b0, v);
      bus(IDX_RELOAD, 1'b1, 8'hAA, 2'b10, 1'b1, v);
      bus(IDX_RELOAD, 1'b0, 8'h00, 2'b01, 1'b1, v);
      chk(v, 8'h00);
      rdc(IDX_RELOAD, 8'hF0);
      for (int e = 1; e >= 0; e--) begin
         ext_ovf(8'(8'h88 | (e << 1)));
         chk(8'(ovf_irq), 8'(e));
         rdc(IDX_COUNTER, 8'hF0);
         rdc(IDX_TIMER_CSR, 8'(8'h89 | (e << 1)));
         rdc(IDX_TIMER_CSR, 8'(8'h88 | (e << 1)));
         chk(8'(ovf_irq), 8'h00);
      end
      // duty change waits for the next overflow
      wr(IDX_TIMER_CSR, 8'h00);
      duty[0] = ~duty[0];
      wr(IDX_DUTY0, duty[0]);
      for (int k = 0; k < 8; k++) begin
         pc = 8'($urandom());
         v = k[0] ? shad[k % 4] : 8'($urandom());
         pwm_chk(pc, v);
         pwm_chk(pc ^ 8'h0F, v);
      end
      ext_ovf(8'h88);
      wr(IDX_TIMER_CSR, 8'h00);
      pwm_chk(8'hF0, shad[0]);
      pwm_chk(8'hF0, 8'(shad[0] + 1));
      // input capture on a stopped counter
      wr(IDX_COUNTER, 8'h3C);
      wr(IDX_CAP_CSR, 8'hFF);
      rdc(IDX_CAP_CSR, 8'h3C);
      wr(IDX_CAP_CSR, 8'h1C);
      i_pins.drive_cap(2'b01);
      chk(8'(cap_irq), 8'h03);
      rdc(IDX_CAP_CSR, 8'h1F);
      wr(IDX_COUNTER, 8'h77);
      i_pins.drive_cap(2'b10);
      i_pins.drive_cap(2'b01);
      rdc(IDX_CAP1, 8'h3C);
      rdc(IDX_CAP_CSR, 8'h1E);
      chk(8'(cap_irq), 8'h02);
      i_pins.drive_cap(2'b00);
      rdc(IDX_CAP_CSR, 8'h1E);
      wr(IDX_CAP_CSR, 8'h18);
      i_pins.drive_cap(2'b01);
      chk(8'(cap_irq), 8'h02);
      rdc(IDX_CAP_CSR, 8'h1B);
      rdc(IDX_CAP1, 8'h77);
      rdc(IDX_CAP2, 8'h3C);
      wr(IDX_CAP_CSR, 8'h20);
      i_pins.drive_cap(2'b11);
      rdc(IDX_CAP_CSR, 8'h22);
      rdc(IDX_CAP2, 8'h77);
      give_verdict();
   end
endmodule // tb_top
